/* File: hdl/occ_pkg.sv */
// Purpose: constants and types of the overcurrent comparator
// Assumes: register index times four gives the byte address
// Notes:   thresholds and filter data are signed 16 bit
// How it works
// - enable bit runs the fast filter and comparator while i_chan_en is high, clear stops both
// - fast filter is held cleared while the channel is stopped
// - polarity bit picks low or high pin level during a fault
// - fault is active while either threshold event flag is active
// - fault reaches the shared pin only when source select picks it
// - event trips after the programmed count of consecutive exceedances
// - fast filter is third order sinc with fixed ratio 64
// - any sample back inside restarts the count, no hysteresis
// - high event when filter output strictly above high limit
// - high limit 7fff turns high detection off
// - limits and filter output compare as signed 16 bit numbers
// - low event when strictly below low limit, 8000 turns it off
package occ_pkg;

	// ----------------------------------------------------------
	// register map, word index per register
	// ----------------------------------------------------------
	localparam int unsigned AW = 10;
	localparam int unsigned DW = 16;
	localparam logic [7:0] IDX_CFG  = 8'hc7;
	localparam logic [7:0] IDX_HIGH = 8'hc8;
	localparam logic [7:0] IDX_LOW  = 8'hc9;
	localparam logic [7:0] IDX_STS  = 8'hd0;
	localparam logic [7:0] IDX_CLR  = 8'hd1;
	localparam logic [7:0] IDX_IEN  = 8'hd2;
	localparam logic [7:0] IDX_PIN  = 8'hd3;
	localparam logic [15:0] HIGH_RST = 16'h7fff;
	localparam logic [15:0] LOW_RST  = 16'h8000;
	localparam logic [7:0]  CFG_RST  = 8'h00;
	localparam logic [2:0]  PIN_RST  = 3'h0;
	localparam int unsigned CFG_LSB  = 8;
	localparam int unsigned PIN_GPO  = 0;
	localparam int unsigned PIN_SRC  = 1;
	localparam int unsigned PIN_FMT  = 2;

	// ----------------------------------------------------------
	// filter and timing
	// ----------------------------------------------------------
	localparam int unsigned SINC_OSR = 64;
	localparam int unsigned SINC_W   = 20;
	localparam int unsigned SINC_SHR = 3;
	localparam int unsigned SETTLE   = 3;
	localparam int unsigned MOD_DIV  = 8;
	localparam int unsigned CNT_W    = 8;

	// ----------------------------------------------------------
	// types
	// ----------------------------------------------------------
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic          wr;
		logic          rd;
	} occ_bus_t;

	// same bit order as config register bits 15..8
	typedef struct packed {
		logic       en;
		logic       pol;
		logic       rsv;
		logic [4:0] num;
	} occ_cfg_t;

	typedef struct packed {
		logic signed [SINC_W-1:0] i1;
		logic signed [SINC_W-1:0] i2;
		logic signed [SINC_W-1:0] i3;
		logic signed [SINC_W-1:0] p1;
		logic signed [SINC_W-1:0] p2;
		logic signed [SINC_W-1:0] p3;
		logic [5:0]               dec;
		logic [1:0]               settle;
		logic signed [15:0]       out;
		logic                     vld;
	} occ_sinc_t;

	// count code to consecutive samples needed
	function automatic logic [CNT_W-1:0] occ_need(input logic [4:0] c);
		logic [CNT_W-1:0] w;
		w = {3'h0, c};
		if (c < 5'h12)
			return w + 8'h01;
		return (w - 8'h0f) << 3;
	endfunction

endpackage

/* File: hdl/occ_sinc3.sv */
// Purpose: third order sinc decimator for the comparator path
// Assumes: one modulator bit per i_ce pulse
// Notes:   first outputs after a clear are held back until settled
`timescale 1ns/100ps
module occ_sinc3
(
	// clock and reset
	input  wire logic               i_mclk,
	input  wire logic               i_rst,
	// control
	input  wire logic               i_clr,
	input  wire logic               i_ce,
	input  wire logic               i_bit,
	// filtered sample
	output logic signed [15:0]      o_data,
	output logic                    o_vld
);
	localparam int unsigned W = occ_pkg::SINC_W;

	occ_pkg::occ_sinc_t s_r;
	occ_pkg::occ_sinc_t s_nxt;
	logic signed [W-1:0] x;
	logic signed [W-1:0] d1;
	logic signed [W-1:0] d2;
	logic signed [W-1:0] d3;
	logic signed [W-1:0] q;

	// ----------------------------------------------------------
	// integrate at bit rate, differentiate at sample rate
	// ----------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.vld = 1'b0;
		x = i_bit ? 20'sh00001 : -20'sh00001;
		d1 = s_r.i3 - s_r.p1;
		d2 = d1 - s_r.p2;
		d3 = d2 - s_r.p3;
		q = d3 >>> occ_pkg::SINC_SHR;
		if (i_ce)
		begin
			// wraparound sums are harmless in a sinc structure
			s_nxt.i1 = s_r.i1 + x;
			s_nxt.i2 = s_r.i2 + s_r.i1;
			s_nxt.i3 = s_r.i3 + s_r.i2;
			s_nxt.dec = s_r.dec + 6'h01;
			if (s_r.dec == 6'(occ_pkg::SINC_OSR - 1))
			begin
				s_nxt.dec = 6'h00;
				s_nxt.p1 = s_r.i3;
				s_nxt.p2 = d1;
				s_nxt.p3 = d2;
				if (s_r.settle == 2'(occ_pkg::SETTLE))
				begin
					s_nxt.vld = 1'b1;
					// full scale +2^18 would wrap to negative
					if (q > 20'sh07fff)
						s_nxt.out = 16'sh7fff;
					else if (q < -20'sh08000)
						s_nxt.out = -16'sh8000;
					else
						s_nxt.out = q[15:0];
				end
				else
					s_nxt.settle = s_r.settle + 2'h1;
			end
		end
		if (i_clr)
			s_nxt = '0;
	end

	// state register
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign o_data = s_r.out;
	assign o_vld  = s_r.vld;
endmodule

/* File: hdl/occ_comparator.sv */
// Purpose: overcurrent comparator on the second current channel
// Assumes: modulator bit arrives asynchronously on i_mod_bit
// Notes:   registers are 16 bit words, byte address is index * 4
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
module occ_comparator
#(
	parameter int unsigned MOD_DIV = occ_pkg::MOD_DIV
)
(
	// clock and reset
	input  wire logic              i_mclk,
	input  wire logic              i_rst,
	// register port
	input  wire occ_pkg::occ_bus_t i_bus,
	output logic [15:0]            o_rdata,
	// converter side
	input  wire logic              i_mod_bit,
	input  wire logic              i_chan_en,
	// shared pin and interrupt
	output logic                   o_pin_out,
	output logic                   o_pin_oe,
	output logic                   o_irq
);
	localparam int unsigned CW = occ_pkg::CNT_W;

	typedef struct packed {
		logic [2:0]       sync;
		logic             mbit;
		logic [7:0]       div;
		occ_pkg::occ_cfg_t cfg;
		logic [15:0]      hi_th;
		logic [15:0]      lo_th;
		logic [2:0]       pin;
		logic [1:0]       sts;
		logic [1:0]       ien;
		logic [CW-1:0]    cnt_hi;
		logic [CW-1:0]    cnt_lo;
		logic             ht;
		logic             lt;
		logic [15:0]      rdata;
		logic             pout;
		logic             poe;
	} occ_st_t;

	occ_st_t st_r;
	occ_st_t st_nxt;

	logic               tick;
	logic               run;
	logic signed [15:0] y;
	logic               vld;
	logic [CW-1:0]      need;
	logic               hi_x;
	logic               lo_x;
	logic               fault;
	logic               level;
	logic [7:0]         idx;
	logic               sel;
	logic [1:0]         clr;

	// ----------------------------------------------------------
	// fast filter
	// ----------------------------------------------------------
	// channel stop reaches the filter only through its clear input
	occ_sinc3 u_sinc
	(
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_clr  (!run),
		.i_ce   (tick),
		.i_bit  (st_r.mbit),
		.o_data (y),
		.o_vld  (vld)
	);

	// ----------------------------------------------------------
	// combinational terms
	// ----------------------------------------------------------
	// both run only with enable bit and live channel
	assign run  = st_r.cfg.en && i_chan_en;
	assign tick = (st_r.div == 8'(MOD_DIV - 1));
	assign need = occ_pkg::occ_need(st_r.cfg.num);
	// full scale limits switch each side off
	assign hi_x = (st_r.hi_th != occ_pkg::HIGH_RST)
		&& (y > $signed(st_r.hi_th));
	assign lo_x = (st_r.lo_th != occ_pkg::LOW_RST)
		&& (y < $signed(st_r.lo_th));
	assign fault = st_r.ht || st_r.lt;
	assign level = st_r.cfg.pol ? fault : !fault;
	assign idx   = i_bus.addr[9:2];
	assign sel   = (i_bus.addr[1:0] == 2'h0);
	assign clr   = (i_bus.wr && sel && idx == occ_pkg::IDX_CLR)
		? i_bus.wdata[1:0] : 2'h0;

	// ----------------------------------------------------------
	// next state
	// ----------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rdata = 16'h0000;

		// three stage pin synchroniser, accept when the last two stages agree
		st_nxt.sync = {st_r.sync[1:0], i_mod_bit};
		if (st_r.sync[1] == st_r.sync[2])
			st_nxt.mbit = st_r.sync[2];

		// modulator bit rate enable
		st_nxt.div = tick ? 8'h00 : st_r.div + 8'h01;

		// deglitch counters, one step per filter sample
		if (vld)
		begin
			if (hi_x)
			begin
				if (st_r.cnt_hi != 8'hff)
					st_nxt.cnt_hi = st_r.cnt_hi + 8'h01;
				if (st_r.cnt_hi + 8'h01 >= need)
					st_nxt.ht = 1'b1;
			end
			else
			begin
				st_nxt.cnt_hi = 8'h00;
				st_nxt.ht = 1'b0;
			end
			if (lo_x)
			begin
				if (st_r.cnt_lo != 8'hff)
					st_nxt.cnt_lo = st_r.cnt_lo + 8'h01;
				if (st_r.cnt_lo + 8'h01 >= need)
					st_nxt.lt = 1'b1;
			end
			else
			begin
				st_nxt.cnt_lo = 8'h00;
				st_nxt.lt = 1'b0;
			end
		end
		if (!run)
		begin
			st_nxt.cnt_hi = 8'h00;
			st_nxt.cnt_lo = 8'h00;
			st_nxt.ht = 1'b0;
			st_nxt.lt = 1'b0;
		end

		// sticky status: a new rise wins over a clear
		st_nxt.sts = (st_r.sts & ~clr)
			| {st_nxt.lt & ~st_r.lt, st_nxt.ht & ~st_r.ht};

		// register writes
		if (i_bus.wr && sel)
		begin
			case (idx)
				occ_pkg::IDX_CFG:
					st_nxt.cfg = occ_pkg::occ_cfg_t'(i_bus.wdata[15:8]);
				occ_pkg::IDX_HIGH:
					st_nxt.hi_th = i_bus.wdata;
				occ_pkg::IDX_LOW:
					st_nxt.lo_th = i_bus.wdata;
				occ_pkg::IDX_IEN:
					st_nxt.ien = i_bus.wdata[1:0];
				occ_pkg::IDX_PIN:
					st_nxt.pin = i_bus.wdata[2:0];
				default:
					st_nxt.ien = st_r.ien;
			endcase
		end

		// register reads, answered one cycle later
		if (i_bus.rd && sel)
		begin
			case (idx)
				occ_pkg::IDX_CFG:
					st_nxt.rdata = {st_r.cfg, 8'h00};
				occ_pkg::IDX_HIGH:
					st_nxt.rdata = st_r.hi_th;
				occ_pkg::IDX_LOW:
					st_nxt.rdata = st_r.lo_th;
				occ_pkg::IDX_STS:
					st_nxt.rdata = {14'h0000, st_r.sts};
				occ_pkg::IDX_IEN:
					st_nxt.rdata = {14'h0000, st_r.ien};
				occ_pkg::IDX_PIN:
					st_nxt.rdata = {13'h0000, st_r.pin};
				default:
					st_nxt.rdata = 16'h0000;
			endcase
		end

		// shared pin: source then push-pull or open-drain format
		if (st_r.pin[occ_pkg::PIN_SRC])
			st_nxt.pout = level;
		else
			st_nxt.pout = st_r.pin[occ_pkg::PIN_GPO];
		if (st_r.pin[occ_pkg::PIN_FMT])
		begin
			// open drain only ever pulls low
			st_nxt.poe = !st_nxt.pout;
			st_nxt.pout = 1'b0;
		end
		else
			st_nxt.poe = 1'b1;
	end

	// state register
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			st_r <= '0;
			st_r.cfg <= occ_pkg::CFG_RST;
			st_r.hi_th <= occ_pkg::HIGH_RST;
			st_r.lo_th <= occ_pkg::LOW_RST;
			st_r.pin <= occ_pkg::PIN_RST;
		end
		else
			st_r <= st_nxt;
	end

	// outputs
	assign o_rdata   = st_r.rdata;
	assign o_pin_out = st_r.pout;
	assign o_pin_oe  = st_r.poe;
	assign o_irq     = |(st_r.sts & st_r.ien);

	// ----------------------------------------------------------
	// assertions
	// ----------------------------------------------------------
	property p_off;
		@(posedge i_mclk) disable iff (i_rst)
		!run |=> !st_r.ht && !st_r.lt && st_r.cnt_hi == 8'h00;
	endproperty
	a_off: assert property (p_off)
		else $error("flags set while comparator off");

	property p_pol;
		@(posedge i_mclk) disable iff (i_rst)
		st_r.pin == 3'h2 && st_r.ht |=> o_pin_out == $past(st_r.cfg.pol);
	endproperty
	a_pol: assert property (p_pol)
		else $error("fault pin level ignores polarity");

	property p_or;
		@(posedge i_mclk) disable iff (i_rst)
		st_r.pin == 3'h2 && st_r.lt && !st_r.ht
			|=> o_pin_out == $past(st_r.cfg.pol);
	endproperty
	a_or: assert property (p_or)
		else $error("low event does not show as fault");

	property p_src;
		@(posedge i_mclk) disable iff (i_rst)
		!st_r.pin[1] && !st_r.pin[2] |=> o_pin_out == $past(st_r.pin[0]);
	endproperty
	a_src: assert property (p_src)
		else $error("fault leaks onto unselected pin");

	property p_cnt;
		@(posedge i_mclk) disable iff (i_rst)
		$rose(st_r.ht) |-> st_r.cnt_hi >= $past(need);
	endproperty
	a_cnt: assert property (p_cnt)
		else $error("high event before deglitch count");

	property p_rst;
		@(posedge i_mclk) disable iff (i_rst)
		vld && run && !hi_x |=> st_r.cnt_hi == 8'h00 && !st_r.ht;
	endproperty
	a_rst: assert property (p_rst)
		else $error("count not restarted inside limit");

	property p_eq;
		@(posedge i_mclk) disable iff (i_rst)
		vld && y == $signed(st_r.hi_th) |=> st_r.cnt_hi == 8'h00;
	endproperty
	a_eq: assert property (p_eq)
		else $error("equal value counted as exceedance");

	property p_hoff;
		@(posedge i_mclk) disable iff (i_rst)
		vld && st_r.hi_th == 16'h7fff |=> !st_r.ht;
	endproperty
	a_hoff: assert property (p_hoff)
		else $error("high detection active at 7fff");

	property p_loff;
		@(posedge i_mclk) disable iff (i_rst)
		vld && st_r.lo_th == 16'h8000 |=> st_r.cnt_lo == 8'h00;
	endproperty
	a_loff: assert property (p_loff)
		else $error("low detection active at 8000");

	property p_clr;
		@(posedge i_mclk) disable iff (i_rst)
		vld && !hi_x && !lo_x |=> !fault;
	endproperty
	a_clr: assert property (p_clr)
		else $error("fault stays with no event");

	c_ht: cover property (@(posedge i_mclk) $rose(st_r.ht));
	c_lt: cover property (@(posedge i_mclk) $rose(st_r.lt));
	c_irq: cover property (@(posedge i_mclk) $rose(o_irq));
endmodule

/* File: testbench/occ_far_model.sv */
// Purpose: far side of the comparator, modulator source and pin pull-up
// Assumes: a constant bitstream gives a full-scale filter output
// Notes:   the pin is resolved here as the host would see it
`timescale 1ns/100ps
module occ_far_model
(
	// clock
	input  wire logic i_mclk,
	// stimulus and pin
	input  wire logic i_ones,
	input  wire logic i_pin_out,
	input  wire logic i_pin_oe,
	// resolved signals
	output logic      o_mod_bit,
	output logic      o_pin_level
);
	// ------------------------------------------------------
	// modulator bit, changed just after the edge
	// ------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		o_mod_bit <= i_ones;
	end

	// pull-up, so a released open-drain pin reads high
	assign o_pin_level = i_pin_oe ? i_pin_out : 1'b1;
endmodule

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench of the overcurrent comparator
// Assumes: MOD_DIV of 1, so one filter sample every 64 clocks
// Notes:   waits are clock counts with a margin of a few samples
`timescale 1ns/100ps
module tb_top;
	// ------------------------------------------------------
	// clock, stimulus and wiring
	// ------------------------------------------------------
	logic              i_mclk     = 1'b0;
	logic              i_rst      = 1'b1;
	occ_pkg::occ_bus_t bus        = '0;
	logic              ones       = 1'b1;
	logic [15:0]       rdata;
	logic              mod_bit;
	logic              pin_out;
	logic              pin_oe;
	logic              irq;
	logic              pin_lvl;
	logic              chan_en    = 1'b1;
	int                mismatches = 0;
	int                cmp_count  = 0;
	logic [4:0]        codes [4]  = '{5'h00, 5'h11, 5'h12, 5'h1f};
	int                needs [4]  = '{1, 18, 24, 128};

	always #5 i_mclk = ~i_mclk;

	// channel kept on whenever the comparator is relied upon
	occ_comparator #(.MOD_DIV(1)) DUT
	(
		.i_mclk    (i_mclk),
		.i_rst     (i_rst),
		.i_bus     (bus),
		.o_rdata   (rdata),
		.i_mod_bit (mod_bit),
		.i_chan_en (chan_en),
		.o_pin_out (pin_out),
		.o_pin_oe  (pin_oe),
		.o_irq     (irq)
	);

	occ_far_model far
	(
		.i_mclk      (i_mclk),
		.i_ones      (ones),
		.i_pin_out   (pin_out),
		.i_pin_oe    (pin_oe),
		.o_mod_bit   (mod_bit),
		.o_pin_level (pin_lvl)
	);

	// ------------------------------------------------------
	// tasks
	// ------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [7:0] idx, input logic [15:0] d);
		@(posedge i_mclk);
		bus <= '{addr: {idx, 2'h0}, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_mclk);
		bus <= '0;
	endtask

	// data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] idx, input logic [15:0] e);
		@(posedge i_mclk);
		bus <= '{addr: {idx, 2'h0}, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge i_mclk);
		bus <= '0;
		#1;
		chk(rdata, e);
	endtask

	// let outputs land after the edge before looking
	task automatic settle(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask

	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ------------------------------------------------------
	// watchdog, about four times the expected run
	// ------------------------------------------------------
	initial
	begin
		repeat (60000) @(posedge i_mclk);
		mismatches++;
		report_and_stop();
	end

	// ------------------------------------------------------
	// main sequence
	// ------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge i_mclk);
		i_rst <= 1'b0;
		// reset values, unmapped read and low byte reading zero
		rd(occ_pkg::IDX_CFG, 16'h0000);
		rd(occ_pkg::IDX_HIGH, 16'h7fff);
		rd(occ_pkg::IDX_LOW, 16'h8000);
		rd(occ_pkg::IDX_STS, 16'h0000);
		rd(8'hc6, 16'h0000);
		wr(occ_pkg::IDX_HIGH, 16'h1234);
		rd(occ_pkg::IDX_HIGH, 16'h1234);
		wr(occ_pkg::IDX_CFG, 16'hdfff);
		rd(occ_pkg::IDX_CFG, 16'hdf00);
		wr(occ_pkg::IDX_CFG, 16'h0000);
		wr(occ_pkg::IDX_HIGH, 16'h7fff);
		// full scale against the disabling limit stays quiet
		wr(occ_pkg::IDX_PIN, 16'h0002);
		wr(occ_pkg::IDX_CFG, 16'hc000);
		settle(600);
		rd(occ_pkg::IDX_STS, 16'h0000);
		chk({15'h0, pin_lvl}, 16'h0000);
		// one code below full scale must trip
		wr(occ_pkg::IDX_HIGH, 16'h7ffe);
		settle(200);
		rd(occ_pkg::IDX_STS, 16'h0001);
		chk({15'h0, pin_lvl}, 16'h0001);
		// interrupt raised, masked, cleared
		wr(occ_pkg::IDX_IEN, 16'h0001);
		settle(3);
		chk({15'h0, irq}, 16'h0001);
		wr(occ_pkg::IDX_IEN, 16'h0000);
		settle(3);
		chk({15'h0, irq}, 16'h0000);
		wr(occ_pkg::IDX_IEN, 16'h0001);
		wr(occ_pkg::IDX_CLR, 16'h0001);
		settle(3);
		chk({15'h0, irq}, 16'h0000);
		rd(occ_pkg::IDX_STS, 16'h0000);
		// active-low polarity, then pin given back to its own value
		wr(occ_pkg::IDX_CFG, 16'h8000);
		settle(3);
		chk({15'h0, pin_lvl}, 16'h0000);
		wr(occ_pkg::IDX_PIN, 16'h0001);
		settle(3);
		chk({15'h0, pin_lvl}, 16'h0001);
		// open drain pulls low during the fault
		wr(occ_pkg::IDX_PIN, 16'h0006);
		settle(3);
		chk({14'h0, pin_oe, pin_out}, 16'h0002);
		// back inside: fault and pin drive go away
		@(posedge i_mclk);
		ones <= 1'b0;
		settle(400);
		chk({14'h0, pin_oe, pin_lvl}, 16'h0001);
		rd(occ_pkg::IDX_STS, 16'h0000);
		// a sample equal to the high limit is no exceedance
		wr(occ_pkg::IDX_HIGH, 16'h8000);
		// lowest sample under a raised low limit trips, push-pull pin
		wr(occ_pkg::IDX_PIN, 16'h0002);
		wr(occ_pkg::IDX_LOW, 16'h8001);
		settle(200);
		rd(occ_pkg::IDX_STS, 16'h0002);
		chk({15'h0, pin_lvl}, 16'h0000);
		// disabled comparator drops the fault and stays idle
		wr(occ_pkg::IDX_CFG, 16'h0000);
		settle(3);
		chk({15'h0, pin_lvl}, 16'h0001);
		wr(occ_pkg::IDX_CLR, 16'h0003);
		settle(600);
		rd(occ_pkg::IDX_STS, 16'h0000);
		// enabled comparator on a stopped channel must stay idle too
		@(posedge i_mclk);
		chan_en <= 1'b0;
		wr(occ_pkg::IDX_CFG, 16'h8000);
		settle(600);
		rd(occ_pkg::IDX_STS, 16'h0000);
		chk({15'h0, pin_lvl}, 16'h0001);
		// deglitch counts at both ends and around the table knee
		@(posedge i_mclk);
		ones    <= 1'b1;
		chan_en <= 1'b1;
		wr(occ_pkg::IDX_LOW, 16'h8000);
		for (int k = 0; k < 4; k++)
		begin
			wr(occ_pkg::IDX_CFG, 16'h0000);
			wr(occ_pkg::IDX_CLR, 16'h0003);
			wr(occ_pkg::IDX_CFG, {3'h4, codes[k], 8'h00});
			// look between sample need-1 and sample need
			settle(220 + (needs[k] - 1) * 64);
			rd(occ_pkg::IDX_STS, 16'h0000);
			settle(250);
			rd(occ_pkg::IDX_STS, 16'h0001);
		end
		report_and_stop();
	end
endmodule
